// ===== ocrs_pkg.sv
// package: register map, field positions and codes of the output clock rate selector
package ocrs_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LF_SRC = 8'h35;
  localparam logic [7:0] ADDR_SYNTH_STD = 8'h38;
  localparam logic [7:0] ADDR_SYNTH_SEL = 8'h39;
  localparam logic [7:0] ADDR_P12 = 8'h60;
  localparam logic [7:0] ADDR_P34 = 8'h61;
  localparam logic [7:0] ADDR_P56 = 8'h62;
  localparam logic [7:0] ADDR_P7EN = 8'h63;
  localparam logic [7:0] ADDR_AUX_MODE = 8'h64;
  localparam logic [7:0] ADDR_MAIN_MODE = 8'h65;
  localparam logic [7:0] ADDR_SYNC_CTL = 8'h7A;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LF_SRC_BIT = 4;
  localparam int AUX_FB_BIT = 6;
  localparam int SYNTH_A_STD_BIT = 5;
  localparam int SYNTH_B_STD_BIT = 6;
  localparam int SYNTH_A_LSB = 4;
  localparam int SYNTH_B_LSB = 6;
  localparam int MODE_LSB = 0;
  localparam int SHARE_FREQ_LSB = 4;
  localparam int SHARE_EN_BIT = 6;
  localparam int COMP_EN_BIT = 4;
  localparam int LINE_EN_BIT = 5;
  localparam int FRAME_DIS_BIT = 6;
  localparam int MFRAME_DIS_BIT = 7;
  localparam int SYNC_2K_PULSE_BIT = 0;
  localparam int SYNC_2K_INV_BIT = 1;
  localparam int SYNC_8K_PULSE_BIT = 2;
  localparam int SYNC_8K_INV_BIT = 3;
  localparam int SYNC_SRC_BIT = 7;

  // ---------------------------------------------------------------
  // per-port selector codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_OFF = 4'h0;
  localparam logic [3:0] SEL_2K = 4'h1;
  localparam logic [3:0] SEL_8K = 4'h2;
  localparam logic [3:0] SEL_SYN_B = 4'h3;
  localparam logic [3:0] SEL_SYN_A = 4'h4;
  localparam logic [3:0] SEL_M48 = 4'h5;
  localparam logic [3:0] SEL_M16 = 4'h6;
  localparam logic [3:0] SEL_M12 = 4'h7;
  localparam logic [3:0] SEL_M8 = 4'h8;
  localparam logic [3:0] SEL_M6 = 4'h9;
  localparam logic [3:0] SEL_M4 = 4'hA;
  localparam logic [3:0] SEL_A64 = 4'hB;
  localparam logic [3:0] SEL_A48 = 4'hC;
  localparam logic [3:0] SEL_A16 = 4'hD;
  localparam logic [3:0] SEL_A8 = 4'hE;
  localparam logic [3:0] SEL_A4 = 4'hF;

  // divider span: common multiple of every tap, so all taps stay phase aligned
  localparam int DIV_SPAN = 192;
  localparam logic [2:0] MAIN_MODE_LAST = 3'h5;

  // port indices with special tap tables, and the port that times sync pulses (zero based)
  localparam int PORT_FOUR = 3;
  localparam int PORT_FIVE = 4;
  localparam int PORT_SIX = 5;
  localparam int PORT_SEVEN = 6;
  localparam int PORT_THREE = 2;

  // sync channel indices
  localparam int SYNC_PORT_2K = 0;
  localparam int SYNC_PORT_8K = 1;
  localparam int SYNC_MFRAME = 2;
  localparam int SYNC_FRAME = 3;

  typedef struct packed {
    logic std_sonet;
    logic [1:0] code;
  } ocrs_synth_sel_s;

  typedef struct packed {
    logic [2:0] main_mode;
    logic main_mode_bad;
    logic [2:0] aux_mode;
    logic aux_from_main;
    logic [1:0] share_freq;
    logic aux_analog_fb;
    logic lf_from_aux;
  } ocrs_path_cfg_s;
endpackage : ocrs_pkg

// ===== ocrs_top.sv
// output clock rate selector: registers, tap dividers, port muxes and sync shaping
`timescale 1ns/1ns
`default_nettype none
module ocrs_top #(
  parameter int NUM_PORTS = 7
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_main_analog_multiplier_pll_clk,
  input wire logic i_aux_analog_multiplier_pll_clk,
  input wire logic i_synth_a_clk,
  input wire logic i_synth_b_clk,
  input wire logic i_main_2k,
  input wire logic i_main_8k,
  input wire logic i_aux_2k,
  input wire logic i_aux_8k,
  input wire logic i_main_comp_clk,
  input wire logic i_aux_comp_clk,
  input wire logic i_main_line_clk,
  input wire logic i_aux_line_clk,
  output logic [NUM_PORTS-1:0] o_port_clk,
  output logic o_composite_clock_out,
  output logic o_line_rate_clock_out,
  output logic o_frame_sync_out,
  output logic o_multiframe_sync_out,
  output ocrs_pkg::ocrs_path_cfg_s o_path_cfg,
  output ocrs_pkg::ocrs_synth_sel_s o_synth_freq_a,
  output ocrs_pkg::ocrs_synth_sel_s o_synth_freq_b
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] lf_src_reg;
  logic [7:0] synth_std_reg;
  logic [7:0] synth_sel_reg;
  logic [7:0] p12_reg;
  logic [7:0] p34_reg;
  logic [7:0] p56_reg;
  logic [7:0] p7en_reg;
  logic [7:0] aux_mode_reg;
  logic [7:0] main_mode_reg;
  logic [7:0] sync_ctl_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lf_src_reg <= ocrs_pkg::RESET_VAL;
      synth_std_reg <= ocrs_pkg::RESET_VAL;
      synth_sel_reg <= ocrs_pkg::RESET_VAL;
      p12_reg <= ocrs_pkg::RESET_VAL;
      p34_reg <= ocrs_pkg::RESET_VAL;
      p56_reg <= ocrs_pkg::RESET_VAL;
      p7en_reg <= ocrs_pkg::RESET_VAL;
      aux_mode_reg <= ocrs_pkg::RESET_VAL;
      main_mode_reg <= ocrs_pkg::RESET_VAL;
      sync_ctl_reg <= ocrs_pkg::RESET_VAL;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        ocrs_pkg::ADDR_LF_SRC: lf_src_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_SYNTH_STD: synth_std_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_SYNTH_SEL: synth_sel_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_P12: p12_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_P34: p34_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_P56: p56_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_P7EN: p7en_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_AUX_MODE: aux_mode_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_MAIN_MODE: main_mode_reg <= i_reg_wdata;
        ocrs_pkg::ADDR_SYNC_CTL: sync_ctl_reg <= i_reg_wdata;
        default: begin
          // writes to other offsets are dropped
        end
      endcase
    end
  end

  // registered read data, zero for unmapped offsets
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= ocrs_pkg::RESET_VAL;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ocrs_pkg::ADDR_LF_SRC: o_reg_rdata <= lf_src_reg;
        ocrs_pkg::ADDR_SYNTH_STD: o_reg_rdata <= synth_std_reg;
        ocrs_pkg::ADDR_SYNTH_SEL: o_reg_rdata <= synth_sel_reg;
        ocrs_pkg::ADDR_P12: o_reg_rdata <= p12_reg;
        ocrs_pkg::ADDR_P34: o_reg_rdata <= p34_reg;
        ocrs_pkg::ADDR_P56: o_reg_rdata <= p56_reg;
        ocrs_pkg::ADDR_P7EN: o_reg_rdata <= p7en_reg;
        ocrs_pkg::ADDR_AUX_MODE: o_reg_rdata <= aux_mode_reg;
        ocrs_pkg::ADDR_MAIN_MODE: o_reg_rdata <= main_mode_reg;
        ocrs_pkg::ADDR_SYNC_CTL: o_reg_rdata <= sync_ctl_reg;
        default: o_reg_rdata <= ocrs_pkg::RESET_VAL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // path configuration
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_path_cfg <= '0;
      o_synth_freq_a <= '0;
      o_synth_freq_b <= '0;
    end else begin
      o_path_cfg.main_mode <= main_mode_reg[ocrs_pkg::MODE_LSB +: 3];
      o_path_cfg.main_mode_bad <= (main_mode_reg[ocrs_pkg::MODE_LSB +: 3] > ocrs_pkg::MAIN_MODE_LAST);
      o_path_cfg.aux_from_main <= main_mode_reg[ocrs_pkg::SHARE_EN_BIT];
      // aux mode field is meaningless while the aux multiplier follows the main path
      o_path_cfg.aux_mode <= main_mode_reg[ocrs_pkg::SHARE_EN_BIT] ? 3'h0
                             : aux_mode_reg[ocrs_pkg::MODE_LSB +: 3];
      o_path_cfg.share_freq <= main_mode_reg[ocrs_pkg::SHARE_EN_BIT]
                               ? main_mode_reg[ocrs_pkg::SHARE_FREQ_LSB +: 2] : 2'h0;
      o_path_cfg.aux_analog_fb <= ~lf_src_reg[ocrs_pkg::AUX_FB_BIT];
      o_path_cfg.lf_from_aux <= lf_src_reg[ocrs_pkg::LF_SRC_BIT];
      o_synth_freq_a.std_sonet <= synth_std_reg[ocrs_pkg::SYNTH_A_STD_BIT];
      o_synth_freq_a.code <= synth_sel_reg[ocrs_pkg::SYNTH_A_LSB +: 2];
      o_synth_freq_b.std_sonet <= synth_std_reg[ocrs_pkg::SYNTH_B_STD_BIT];
      o_synth_freq_b.code <= synth_sel_reg[ocrs_pkg::SYNTH_B_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------
  // tap dividers on both multiplier outputs
  // ---------------------------------------------------------------
  function automatic logic tap(input logic [7:0] cnt, input int div);
    int phase;
    phase = int'(cnt) % div;
    return (phase < div / 2);
  endfunction

  logic main_analog_multiplier_pll_d_reg;
  logic aux_analog_multiplier_pll_d_reg;
  logic [7:0] main_cnt_reg;
  logic [7:0] aux_cnt_reg;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      main_analog_multiplier_pll_d_reg <= 1'b0;
      aux_analog_multiplier_pll_d_reg <= 1'b0;
      main_cnt_reg <= 8'h00;
      aux_cnt_reg <= 8'h00;
    end else begin
      main_analog_multiplier_pll_d_reg <= i_main_analog_multiplier_pll_clk;
      aux_analog_multiplier_pll_d_reg <= i_aux_analog_multiplier_pll_clk;
      if (i_main_analog_multiplier_pll_clk && !main_analog_multiplier_pll_d_reg) begin
        main_cnt_reg <= (main_cnt_reg == 8'(ocrs_pkg::DIV_SPAN - 1)) ? 8'h00 : main_cnt_reg + 8'h01;
      end
      if (i_aux_analog_multiplier_pll_clk && !aux_analog_multiplier_pll_d_reg) begin
        aux_cnt_reg <= (aux_cnt_reg == 8'(ocrs_pkg::DIV_SPAN - 1)) ? 8'h00 : aux_cnt_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // port selection
  // ---------------------------------------------------------------
  logic [3:0] port_sel [NUM_PORTS];
  logic port_2k;
  logic port_8k;
  logic [NUM_PORTS-1:0] port_next;

  always_comb begin
    port_sel[0] = p12_reg[3:0];
    port_sel[1] = p12_reg[7:4];
    port_sel[2] = p34_reg[3:0];
    port_sel[3] = p34_reg[7:4];
    port_sel[4] = p56_reg[3:0];
    port_sel[5] = p56_reg[7:4];
    port_sel[6] = p7en_reg[3:0];
  end

  always_comb begin
    port_next = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      unique case (port_sel[p])
        ocrs_pkg::SEL_OFF: port_next[p] = 1'b0;
        ocrs_pkg::SEL_2K: port_next[p] = port_2k;
        ocrs_pkg::SEL_8K: port_next[p] = port_8k;
        ocrs_pkg::SEL_SYN_B: port_next[p] = (p == ocrs_pkg::PORT_SIX) ? tap(main_cnt_reg, 2)
                                            : i_synth_b_clk;
        ocrs_pkg::SEL_SYN_A: port_next[p] = (p == ocrs_pkg::PORT_SEVEN) ? tap(main_cnt_reg, 2)
                                            : i_synth_a_clk;
        ocrs_pkg::SEL_M48: port_next[p] = (p == ocrs_pkg::PORT_SIX) ? i_main_analog_multiplier_pll_clk
                                          : tap(main_cnt_reg, 48);
        ocrs_pkg::SEL_M16: port_next[p] = tap(main_cnt_reg, 16);
        ocrs_pkg::SEL_M12: port_next[p] = tap(main_cnt_reg, 12);
        ocrs_pkg::SEL_M8: port_next[p] = tap(main_cnt_reg, 8);
        ocrs_pkg::SEL_M6: port_next[p] = tap(main_cnt_reg, 6);
        ocrs_pkg::SEL_M4: port_next[p] = tap(main_cnt_reg, 4);
        ocrs_pkg::SEL_A64: port_next[p] = (p == ocrs_pkg::PORT_FOUR || p == ocrs_pkg::PORT_FIVE)
                                          ? tap(aux_cnt_reg, 2) : tap(aux_cnt_reg, 64);
        ocrs_pkg::SEL_A48: port_next[p] = tap(aux_cnt_reg, 48);
        ocrs_pkg::SEL_A16: port_next[p] = tap(aux_cnt_reg, 16);
        ocrs_pkg::SEL_A8: port_next[p] = tap(aux_cnt_reg, 8);
        ocrs_pkg::SEL_A4: port_next[p] = tap(aux_cnt_reg, 4);
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_clk <= '0;
    end else begin
      o_port_clk <= port_next;
    end
  end

  // ---------------------------------------------------------------
  // composite and line-rate outputs
  // ---------------------------------------------------------------
  // the fixed rates come from the path's own synthesiser, so no mode field is consulted
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_composite_clock_out <= 1'b0;
      o_line_rate_clock_out <= 1'b0;
    end else begin
      o_composite_clock_out <= p7en_reg[ocrs_pkg::COMP_EN_BIT]
                               & (lf_src_reg[ocrs_pkg::LF_SRC_BIT] ? i_aux_comp_clk
                                  : i_main_comp_clk);
      o_line_rate_clock_out <= p7en_reg[ocrs_pkg::LINE_EN_BIT]
                               & (lf_src_reg[ocrs_pkg::LF_SRC_BIT] ? i_aux_line_clk
                                  : i_main_line_clk);
    end
  end

  // ---------------------------------------------------------------
  // sync shaping: clock or one port-three-cycle pulse, optional inversion
  // ---------------------------------------------------------------
  logic [3:0] sync_src;
  logic [3:0] sync_src_d_reg;
  logic [3:0] sync_armed_reg;
  logic [3:0] sync_pulse_reg;
  logic [3:0] sync_pulse_mode;
  logic [3:0] sync_invert;
  logic [3:0] sync_shaped;
  logic port3_d_reg;
  logic port3_rise;

  always_comb begin
    sync_src[ocrs_pkg::SYNC_PORT_2K] = sync_ctl_reg[ocrs_pkg::SYNC_SRC_BIT] ? i_aux_2k : i_main_2k;
    sync_src[ocrs_pkg::SYNC_PORT_8K] = sync_ctl_reg[ocrs_pkg::SYNC_SRC_BIT] ? i_aux_8k : i_main_8k;
    sync_src[ocrs_pkg::SYNC_MFRAME] = i_main_2k;
    sync_src[ocrs_pkg::SYNC_FRAME] = i_main_8k;
    sync_pulse_mode = {sync_ctl_reg[ocrs_pkg::SYNC_8K_PULSE_BIT], sync_ctl_reg[ocrs_pkg::SYNC_2K_PULSE_BIT],
                       sync_ctl_reg[ocrs_pkg::SYNC_8K_PULSE_BIT], sync_ctl_reg[ocrs_pkg::SYNC_2K_PULSE_BIT]};
    sync_invert = {sync_ctl_reg[ocrs_pkg::SYNC_8K_INV_BIT], sync_ctl_reg[ocrs_pkg::SYNC_2K_INV_BIT],
                   sync_ctl_reg[ocrs_pkg::SYNC_8K_INV_BIT], sync_ctl_reg[ocrs_pkg::SYNC_2K_INV_BIT]};
    port3_rise = o_port_clk[ocrs_pkg::PORT_THREE] & ~port3_d_reg;
    for (int k = 0; k < 4; k++) begin
      sync_shaped[k] = (sync_pulse_mode[k] ? sync_pulse_reg[k] : sync_src[k]) ^ sync_invert[k];
    end
    port_2k = sync_shaped[ocrs_pkg::SYNC_PORT_2K];
    port_8k = sync_shaped[ocrs_pkg::SYNC_PORT_8K];
  end

  // a slow port-three clock stretches or swallows pulses; it must run at 1544 kHz or more
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      port3_d_reg <= 1'b0;
      sync_src_d_reg <= 4'h0;
      sync_armed_reg <= 4'h0;
      sync_pulse_reg <= 4'h0;
    end else begin
      port3_d_reg <= o_port_clk[ocrs_pkg::PORT_THREE];
      sync_src_d_reg <= sync_src;
      for (int k = 0; k < 4; k++) begin
        if (port3_rise) begin
          sync_pulse_reg[k] <= sync_armed_reg[k];
        end
        // a new source edge wins over the clear in the same cycle
        if (sync_src[k] && !sync_src_d_reg[k]) begin
          sync_armed_reg[k] <= 1'b1;
        end else if (port3_rise) begin
          sync_armed_reg[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_frame_sync_out <= 1'b0;
      o_multiframe_sync_out <= 1'b0;
    end else begin
      o_frame_sync_out <= ~p7en_reg[ocrs_pkg::FRAME_DIS_BIT] & sync_shaped[ocrs_pkg::SYNC_FRAME];
      o_multiframe_sync_out <= ~p7en_reg[ocrs_pkg::MFRAME_DIS_BIT]
                               & sync_shaped[ocrs_pkg::SYNC_MFRAME];
    end
  end

endmodule // ocrs_top
`default_nettype wire

// ===== ocrs_chk.sv
// checker: register-side relations of the output clock rate selector
`timescale 1ns/1ns
`default_nettype none
module ocrs_chk (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire ocrs_pkg::ocrs_path_cfg_s o_path_cfg,
  input wire ocrs_pkg::ocrs_synth_sel_s o_synth_freq_a,
  input wire ocrs_pkg::ocrs_synth_sel_s o_synth_freq_b
);
  // ----------------
  // write decode
  // ----------------
  logic wr35;
  logic wr39;
  logic wr65;
  assign wr35 = i_reg_wr && (i_reg_addr == ocrs_pkg::ADDR_LF_SRC);
  assign wr39 = i_reg_wr && (i_reg_addr == ocrs_pkg::ADDR_SYNTH_SEL);
  assign wr65 = i_reg_wr && (i_reg_addr == ocrs_pkg::ADDR_MAIN_MODE);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  // ----------------
  // assertions
  // ----------------
  // two edges: one into the register, one more for the registered view
  property p_main_mode;
    wr65 |-> ##2 o_path_cfg.main_mode == $past(i_reg_wdata[2:0], 2);
  endproperty
  a_main_mode: assert property (p_main_mode) else $error("main mode not taken");
  property p_main_bad;
    wr65 |-> ##2 o_path_cfg.main_mode_bad == ($past(i_reg_wdata[2:0], 2) > ocrs_pkg::MAIN_MODE_LAST);
  endproperty
  a_main_bad: assert property (p_main_bad) else $error("unused main mode not flagged");
  property p_share_en;
    wr65 |-> ##2 o_path_cfg.aux_from_main == $past(i_reg_wdata[6], 2);
  endproperty
  a_share_en: assert property (p_share_en) else $error("sharing bit not taken");
  property p_aux_ignored;
    o_path_cfg.aux_from_main |-> o_path_cfg.aux_mode == 3'h0;
  endproperty
  a_aux_ignored: assert property (p_aux_ignored) else $error("aux mode used while shared");
  property p_share_freq;
    wr65 && i_reg_wdata[6] |-> ##2 o_path_cfg.share_freq == $past(i_reg_wdata[5:4], 2);
  endproperty
  a_share_freq: assert property (p_share_freq) else $error("shared frequency not taken");
  property p_lf_src;
    wr35 |-> ##2 o_path_cfg.lf_from_aux == $past(i_reg_wdata[4], 2);
  endproperty
  a_lf_src: assert property (p_lf_src) else $error("low rate source not taken");
  property p_aux_fb;
    wr35 |-> ##2 o_path_cfg.aux_analog_fb == !$past(i_reg_wdata[6], 2);
  endproperty
  a_aux_fb: assert property (p_aux_fb) else $error("aux feedback wrong");
  property p_synth_a;
    wr39 |-> ##2 o_synth_freq_a.code == $past(i_reg_wdata[5:4], 2);
  endproperty
  a_synth_a: assert property (p_synth_a) else $error("synth a code wrong");
  property p_synth_b;
    wr39 |-> ##2 o_synth_freq_b.code == $past(i_reg_wdata[7:6], 2);
  endproperty
  a_synth_b: assert property (p_synth_b) else $error("synth b code wrong");
endmodule // ocrs_chk

bind ocrs_top ocrs_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata),
  .o_path_cfg(o_path_cfg),
  .o_synth_freq_a(o_synth_freq_a),
  .o_synth_freq_b(o_synth_freq_b)
);
`default_nettype wire

// ===== ocrs_top_bench.sv
// testbench: random and corner stimulus for the output clock rate selector
`timescale 1ns/1ns
`default_nettype none
module ocrs_top_bench;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_rd = 1'b0;
  logic [11:0] src = 12'h000;
  logic [7:0] o_reg_rdata;
  logic [6:0] o_port_clk;
  logic o_comp;
  logic o_line;
  logic o_frame;
  logic o_mframe;
  ocrs_pkg::ocrs_path_cfg_s path_cfg;
  ocrs_pkg::ocrs_synth_sel_s syn_a;
  ocrs_pkg::ocrs_synth_sel_s syn_b;
  wire logic [10:0] obs = {o_mframe, o_frame, o_line, o_comp, o_port_clk};
  // half periods: analog_multiplier_pll main/aux, synth a/b, 2k/8k main, 2k/8k aux, comp main/aux, line main/aux
  int half [12] = '{1, 3, 5, 7, 20, 10, 26, 13, 15, 17, 8, 9};
  int div [16] = '{0, 0, 0, 0, 0, 48, 16, 12, 8, 6, 4, 64, 48, 16, 8, 4};
  int corner [3] = '{3, 5, 6};
  logic [7:0] regs [10] = '{8'h35, 8'h38, 8'h39, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h7A};
  logic [7:0] shadow [256];
  int cyc = 0;
  int ticks = 0;
  int seed = 32'h64C1;
  int bad_count = 0;
  int cmp_count = 0;

  ocrs_top uut (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_main_analog_multiplier_pll_clk(src[0]), .i_aux_analog_multiplier_pll_clk(src[1]), .i_synth_a_clk(src[2]), .i_synth_b_clk(src[3]),
    .i_main_2k(src[4]), .i_main_8k(src[5]), .i_aux_2k(src[6]), .i_aux_8k(src[7]),
    .i_main_comp_clk(src[8]), .i_aux_comp_clk(src[9]), .i_main_line_clk(src[10]), .i_aux_line_clk(src[11]),
    .o_port_clk(o_port_clk), .o_composite_clock_out(o_comp), .o_line_rate_clock_out(o_line),
    .o_frame_sync_out(o_frame), .o_multiframe_sync_out(o_mframe), .o_path_cfg(path_cfg),
    .o_synth_freq_a(syn_a), .o_synth_freq_b(syn_b)
  );

  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // ----------------
  // source clocks, all synchronous levels
  // ----------------
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    for (int k = 0; k < 12; k++) src[k] <= ((cyc / half[k]) % 2) == 1;
  end
  always @(posedge i_clk_sys) begin
    ticks <= ticks + 1;
    if (ticks == 60000) begin
      bad_count++;
      close_out();
    end
  end
  // ----------------
  // helpers
  // ----------------
  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    shadow[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk_byte(o_reg_rdata, shadow[a]);
  endtask
  task automatic set_port(input int p, input logic [3:0] c);
    logic [7:0] a;
    logic [7:0] d;
    a = 8'h60 + 8'(p / 2);
    d = shadow[a];
    if (p % 2 == 1) d[7:4] = c;
    else d[3:0] = c;
    wr(a, d);
  endtask
  // settle first, so a switch-over glitch is never taken as an edge
  task automatic meas(input int idx, input logic lvl, output int per, output int wid);
    int n;
    logic prev;
    per = 0;
    wid = 0;
    n = 0;
    repeat (8) @(negedge i_clk_sys);
    prev = obs[idx];
    @(negedge i_clk_sys);
    while (n < 1000 && !(obs[idx] === lvl && prev !== lvl)) begin
      prev = obs[idx];
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 1000) return;
    while (obs[idx] === lvl && wid < 1000) begin
      @(negedge i_clk_sys);
      wid++;
    end
    per = wid;
    while (obs[idx] !== lvl && per < 2000) begin
      @(negedge i_clk_sys);
      per++;
    end
  endtask
  task automatic chk_out(input int idx, input int exp);
    int per;
    int wid;
    meas(idx, 1'b1, per, wid);
    chk_cnt(16'(per), 16'(exp));
    if (exp == 0) chk_cnt({15'h0, obs[idx]}, 16'h0);
  endtask
  // period in system cycles of a port for a selector code
  function automatic int exp_per(input int p, input logic [3:0] c, input logic aux);
    if (c == 4'h0) return 0;
    if (c == 4'h1) return 2 * (aux ? half[6] : half[4]);
    if (c == 4'h2) return 2 * (aux ? half[7] : half[5]);
    if (c == 4'h3) return (p == 5) ? 4 : 2 * half[3];
    if (c == 4'h4) return (p == 6) ? 4 : 2 * half[2];
    if (c == 4'h5 && p == 5) return 2;
    if (c == 4'hB && (p == 3 || p == 4)) return 12;
    return (c < 4'hB) ? 2 * div[c] : 6 * div[c];
  endfunction
  // ----------------
  // main sequence
  // ----------------
  initial begin
    int p;
    int i;
    int h;
    int b;
    int per;
    int wid;
    logic [7:0] r;
    logic [7:0] d;
    logic [3:0] c;
    logic [11:0] e;
    for (i = 0; i < 256; i++) shadow[i] = 8'h00;
    repeat (3) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    for (i = 0; i < 10; i++) rd(regs[i]);
    wr(8'h66, 8'hA5);
    shadow[8'h66] = 8'h00;
    rd(8'h66);
    for (i = 0; i < 68; i++) begin
      r = 8'($random(seed));
      p = (i < 48) ? corner[i / 16] : (r[7:4] % 7);
      c = (i < 48) ? 4'(i % 16) : r[3:0];
      wr(8'h7A, {r[0], 7'h00});
      set_port(p, c);
      rd(8'h60 + 8'(p / 2));
      chk_out(p, exp_per(p, c, r[0]));
    end
    for (i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      d = {r[7], i[0], r[5:3], i[2:0]};
      wr(8'h65, d);
      wr(8'h64, r);
      wr(8'h35, r);
      wr(8'h38, r);
      wr(8'h39, d);
      repeat (3) @(negedge i_clk_sys);
      e = {d[2:0], d[2:0] > 3'h5, d[6] ? 3'h0 : r[2:0], d[6], d[6] ? d[5:4] : 2'h0, ~r[6], r[4]};
      chk_cnt({4'h0, path_cfg}, {4'h0, e});
      chk_cnt({10'h000, syn_a, syn_b}, {10'h000, r[5], d[5:4], r[6], d[7:6]});
    end
    for (i = 0; i < 10; i++) rd(regs[i]);
    for (i = 0; i < 8; i++) begin
      wr(8'h63, {shadow[8'h63][7:6], i[1:0], shadow[8'h63][3:0]});
      wr(8'h35, {3'h0, i[2], 4'h0});
      wr(8'h65, 8'($random(seed)) & 8'h03);
      chk_out(7, i[0] ? 2 * half[8 + i[2]] : 0);
      chk_out(8, i[1] ? 2 * half[10 + i[2]] : 0);
    end
    // port three at main/4 gives the 8-cycle pulse width
    set_port(2, 4'hA);
    wr(8'h63, shadow[8'h63] & 8'h3F);
    for (i = 0; i < 2; i++) begin
      h = (i == 1) ? half[4] : half[5];
      b = (i == 1) ? 0 : 2;
      wr(8'h7A, 8'h80);
      meas(9 + i, 1'b1, per, wid);
      chk_cnt(16'(per), 16'(2 * h));
      chk_cnt(16'(wid), 16'(h));
      wr(8'h7A, 8'h80 | 8'(1 << b));
      meas(9 + i, 1'b1, per, wid);
      chk_cnt(16'(wid), 16'(exp_per(2, 4'hA, 1'b0)));
      wr(8'h7A, 8'h80 | 8'(3 << b));
      meas(9 + i, 1'b0, per, wid);
      chk_cnt(16'(wid), 16'(exp_per(2, 4'hA, 1'b0)));
      wr(8'h63, shadow[8'h63] | 8'(8'h40 << i));
      chk_out(9 + i, 0);
    end
    close_out();
  end
endmodule // ocrs_top_bench
`default_nettype wire
